// ### hdl/serial_status_regs.sv
// Status, error flags, ninth bits and data buffer of the async serial unit
// Assumes receive/transmit shifters and line sampler sit outside, on CORE_CLK
// Behaviour
// - In nine-bit mode capture received ninth bit with the data byte
// - In eight-bit mode received ninth bit copies bit 7; reset leaves it
// - In nine-bit mode transmit ninth bit goes to shifter with data; reset leaves it
// - Error interrupt when any error flag is set with its own enable
// - Reset clears overrun, noise, framing and parity enables
// - Transmit-empty sets on buffer handoff, requests interrupt, reset sets it
// - Transmit-empty clears on status-one read with flag set then data write
// - Done flag set when empty and idle; clears when item queued; reset sets
// - Receive-full sets on buffer load, interrupts, clears by status-data reads
// - Idle sets on a character length of ones; clears by status-data reads
// - Idle cannot set again until a valid character sets receive-full
// - Overrun keeps old buffer, discards new character, sets overrun flag
// - Data read clears overrun only if seen set at status-one read
// - Noise flag sets on line noise, clears by status-data reads
// - Framing flag sets on zero stop bit, clears by status-data reads
// - Parity flag sets on parity failure, clears by status-data reads
// - Break sets break, framing, receive-full, clears ninth bit in nine-bit mode, no break interrupt
// - Break clears by status-two then data read; rearms after ones on line
// - Active flag sets at first sample slot zero; clears on false start, idle or character done
// - Data offset reads received byte, writes transmit byte; reset leaves it
// - Character length bit selects nine bits when set; reset clears it
`timescale 1ns/1ns
module serial_status_regs
  import serial_status_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire rx_event_s   RX_EVENT,
  input  wire logic        LINE_IDLE_RUN,
  input  wire logic        LINE_ONES,
  input  wire logic        START_SLOT_ZERO,
  input  wire logic        FALSE_START,
  input  wire tx_event_s   TX_EVENT,
  output logic [8:0]       TX_DATA,
  output logic             TX_DATA_VALID,
  output logic             NINE_BIT_MODE,
  output logic             RX_ENABLE,
  output logic             TX_IRQ,
  output logic             RX_IRQ,
  output logic             ERR_IRQ
);

  // Bus address phase capture
  logic       ph_valid_reg;
  logic       ph_write_reg;
  logic [7:0] ph_addr_reg;

  // Registers
  logic [7:0] rx_buf_reg;
  logic [7:0] tx_buf_reg;
  logic       tx_pending_reg;
  logic       rx_ninth_bit;
  logic       tx_ninth_bit;
  logic       overrun_irq_en;
  logic       noise_irq_en;
  logic       framing_irq_en;
  logic       parity_irq_en;
  logic [7:0] ctrl_one_reg;
  logic       tx_buffer_empty_flag;
  logic       tx_done_flag;
  logic       rx_buffer_full_flag;
  logic       idle_flag;
  logic       overrun_flag;
  logic       rx_noise_flag;
  logic       framing_err_flag;
  logic       parity_err_flag;
  logic       break_detect_flag;
  logic       break_armed_reg;
  logic       idle_armed_reg;
  logic       rx_active_flag;
  logic [7:0] seen_one_reg;
  logic       seen_brk_reg;
  logic       rxen_d_reg;
  logic       tx_queued_reg;

  logic       rd_data;
  logic       wr_data;
  logic       rd_stat_one;
  logic       rd_stat_two;
  logic       wr_ctrl_three;
  logic       wr_ctrl_one;
  logic       rx_accept;
  logic       rx_lost;
  logic [7:0] stat_one;
  logic       nine;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign nine     = ctrl_one_reg[NINE_POS];
  assign stat_one = {tx_buffer_empty_flag, tx_done_flag, rx_buffer_full_flag, idle_flag,
                     overrun_flag, rx_noise_flag, framing_err_flag, parity_err_flag};

  // Data phase decode; status reads snap in the address phase, as the value returned
  always_comb begin
    rd_data       = 1'b0;
    wr_data       = 1'b0;
    rd_stat_one   = HSEL && HREADY && HTRANS[1] && !HWRITE && hit(HADDR[7:0], STAT_ONE_OFFSET);
    rd_stat_two   = HSEL && HREADY && HTRANS[1] && !HWRITE && hit(HADDR[7:0], STAT_TWO_OFFSET);
    wr_ctrl_three = 1'b0;
    wr_ctrl_one   = 1'b0;
    if (ph_valid_reg && hit(ph_addr_reg, DATA_OFFSET)) begin
      rd_data = !ph_write_reg;
      wr_data = ph_write_reg;
    end else if (ph_valid_reg && hit(ph_addr_reg, CTRL_THREE_OFFSET)) begin
      wr_ctrl_three = ph_write_reg;
    end else if (ph_valid_reg && hit(ph_addr_reg, CTRL_ONE_OFFSET)) begin
      wr_ctrl_one = ph_write_reg;
    end
  end

  // New character taken only when buffer is free
  assign rx_accept = RX_EVENT.done && !rx_buffer_full_flag;
  assign rx_lost   = RX_EVENT.done && rx_buffer_full_flag;

  // Address phase
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end else if (CLK_EN) begin
      ph_valid_reg <= HSEL && HREADY && HTRANS[1];
      ph_write_reg <= HWRITE;
      ph_addr_reg  <= HADDR[7:0];
    end
  end

  // Read data, zero-wait OKAY
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (CLK_EN) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
        if (hit(HADDR[7:0], DATA_OFFSET)) begin
          HRDATA <= {24'h000000, rx_buf_reg};
        end else if (hit(HADDR[7:0], STAT_ONE_OFFSET)) begin
          HRDATA <= {24'h000000, stat_one};
        end else if (hit(HADDR[7:0], STAT_TWO_OFFSET)) begin
          HRDATA <= {30'h00000000, break_detect_flag, rx_active_flag};
        end else if (hit(HADDR[7:0], CTRL_THREE_OFFSET)) begin
          HRDATA <= {24'h000000, rx_ninth_bit, tx_ninth_bit, 2'h0, overrun_irq_en,
                     noise_irq_en, framing_irq_en, parity_irq_en};
        end else if (hit(HADDR[7:0], CTRL_ONE_OFFSET)) begin
          HRDATA <= {24'h000000, ctrl_one_reg};
        end
      end
    end
  end

  // Control one: length, receiver enable, interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_one_reg <= CTRL_ONE_RESET;
    end else if (CLK_EN && wr_ctrl_one) begin
      ctrl_one_reg <= HWDATA[7:0];
    end
  end

  // Error interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      {overrun_irq_en, noise_irq_en, framing_irq_en, parity_irq_en} <= ERR_EN_RESET;
    end else if (CLK_EN && wr_ctrl_three) begin
      overrun_irq_en <= HWDATA[OIE_POS];
      noise_irq_en   <= HWDATA[NIE_POS];
      framing_irq_en <= HWDATA[FIE_POS];
      parity_irq_en  <= HWDATA[PIE_POS];
    end
  end

  // Ninth bits and data buffers: untouched by reset
  always_ff @(posedge CORE_CLK) begin
    if (CLK_EN) begin
      if (wr_ctrl_three) begin
        tx_ninth_bit <= HWDATA[TX8_POS];
      end
      if (wr_data) begin
        tx_buf_reg <= HWDATA[7:0];
      end
      if (rx_accept) begin
        rx_buf_reg <= RX_EVENT.data[7:0];
        if (RX_EVENT.brk && nine) begin
          rx_ninth_bit <= 1'b0;
        end else if (nine) begin
          rx_ninth_bit <= RX_EVENT.data[8];
        end else begin
          rx_ninth_bit <= RX_EVENT.data[7];
        end
      end
    end
  end

  // Transmit handoff to the shifter
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      tx_pending_reg <= 1'b0;
      TX_DATA        <= 9'h000;
      TX_DATA_VALID  <= 1'b0;
      tx_queued_reg  <= 1'b0;
    end else if (CLK_EN) begin
      tx_queued_reg <= TX_EVENT.queued;
      if (wr_data) begin
        tx_pending_reg <= 1'b1;
      end else if (TX_EVENT.load) begin
        tx_pending_reg <= 1'b0;
      end
      TX_DATA       <= {nine ? tx_ninth_bit : 1'b0, tx_buf_reg};
      TX_DATA_VALID <= tx_pending_reg && !wr_data && !TX_EVENT.load;
    end
  end

  // Status read snapshot
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      seen_one_reg <= 8'h00;
      seen_brk_reg <= 1'b0;
    end else if (CLK_EN) begin
      if (rd_stat_one) begin
        seen_one_reg <= stat_one;
      end else if (rd_data || wr_data) begin
        seen_one_reg <= 8'h00;
      end
      if (rd_stat_two) begin
        seen_brk_reg <= break_detect_flag;
      end else if (rd_data) begin
        seen_brk_reg <= 1'b0;
      end
    end
  end

  // Transmit flags
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag         <= 1'b1;
    end else if (CLK_EN) begin
      if (TX_EVENT.load) begin
        tx_buffer_empty_flag <= 1'b1;
      end else if (wr_data && seen_one_reg[TXE_POS]) begin
        tx_buffer_empty_flag <= 1'b0;
      end
      if (TX_EVENT.queued || tx_queued_reg) begin
        tx_done_flag <= 1'b0;
      end else begin
        tx_done_flag <= tx_buffer_empty_flag && !tx_pending_reg && !TX_EVENT.busy;
      end
    end
  end

  // Receive flags; set wins over clear
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rx_buffer_full_flag <= 1'b0;
      overrun_flag        <= 1'b0;
      rx_noise_flag       <= 1'b0;
      framing_err_flag    <= 1'b0;
      parity_err_flag     <= 1'b0;
    end else if (CLK_EN) begin
      if (rx_accept) begin
        rx_buffer_full_flag <= 1'b1;
      end else if (rd_data && seen_one_reg[RXF_POS]) begin
        rx_buffer_full_flag <= 1'b0;
      end
      if (rx_lost) begin
        overrun_flag <= 1'b1;
      end else if (rd_data && seen_one_reg[OVR_POS]) begin
        overrun_flag <= 1'b0;
      end
      if (rx_accept && RX_EVENT.noise) begin
        rx_noise_flag <= 1'b1;
      end else if (rd_data && seen_one_reg[NOI_POS]) begin
        rx_noise_flag <= 1'b0;
      end
      if (rx_accept && (RX_EVENT.framing || RX_EVENT.brk)) begin
        framing_err_flag <= 1'b1;
      end else if (rd_data && seen_one_reg[FRM_POS]) begin
        framing_err_flag <= 1'b0;
      end
      if (rx_accept && RX_EVENT.parity) begin
        parity_err_flag <= 1'b1;
      end else if (rd_data && seen_one_reg[PAR_POS]) begin
        parity_err_flag <= 1'b0;
      end
    end
  end

  // Idle flag with arming
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      idle_flag      <= 1'b0;
      idle_armed_reg <= 1'b0;
      rxen_d_reg     <= 1'b0;
    end else if (CLK_EN) begin
      rxen_d_reg <= ctrl_one_reg[RXEN_POS];
      if (rx_accept && !RX_EVENT.brk) begin
        idle_armed_reg <= 1'b1;
      end else if ((ctrl_one_reg[RXEN_POS] && !rxen_d_reg) || (rd_data && seen_one_reg[IDLE_POS])) begin
        idle_armed_reg <= 1'b0;
      end
      if (LINE_IDLE_RUN && idle_armed_reg) begin
        idle_flag <= 1'b1;
      end else if (rd_data && seen_one_reg[IDLE_POS]) begin
        idle_flag <= 1'b0;
      end
    end
  end

  // Break and reception-in-progress
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      break_detect_flag <= 1'b0;
      break_armed_reg   <= 1'b1;
      rx_active_flag    <= 1'b0;
    end else if (CLK_EN) begin
      if (rx_accept && RX_EVENT.brk && break_armed_reg) begin
        break_detect_flag <= 1'b1;
        break_armed_reg   <= 1'b0;
      end else begin
        if (rd_data && seen_brk_reg) begin
          break_detect_flag <= 1'b0;
        end
        if (LINE_ONES && !break_detect_flag) begin
          break_armed_reg <= 1'b1;
        end
      end
      if (START_SLOT_ZERO) begin
        rx_active_flag <= 1'b1;
      end else if (FALSE_START || LINE_IDLE_RUN || RX_EVENT.done) begin
        rx_active_flag <= 1'b0;
      end
    end
  end

  // Interrupt requests and control outputs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      TX_IRQ        <= 1'b0;
      RX_IRQ        <= 1'b0;
      ERR_IRQ       <= 1'b0;
      NINE_BIT_MODE <= 1'b0;
      RX_ENABLE     <= 1'b0;
    end else if (CLK_EN) begin
      TX_IRQ  <= (tx_buffer_empty_flag && ctrl_one_reg[TEI_POS]) ||
                 (tx_done_flag && ctrl_one_reg[TCI_POS]);
      RX_IRQ  <= (rx_buffer_full_flag && ctrl_one_reg[RFI_POS]) ||
                 (idle_flag && ctrl_one_reg[ILI_POS]);
      ERR_IRQ <= (overrun_flag && overrun_irq_en) || (rx_noise_flag && noise_irq_en) ||
                 (framing_err_flag && framing_irq_en) || (parity_err_flag && parity_irq_en);
      NINE_BIT_MODE <= nine;
      RX_ENABLE     <= ctrl_one_reg[RXEN_POS];
    end
  end

endmodule // serial_status_regs

// ### hdl/serial_status_pkg.sv
// Package for the serial status, error-flag and data-buffer block
// Assumes a 32-bit AHB-Lite register bus and one 50 MHz clock
package serial_status_pkg;

  localparam logic [7:0] DATA_OFFSET    = 8'h18;
  localparam logic [7:0] STAT_ONE_OFFSET = 8'h1c;
  localparam logic [7:0] STAT_TWO_OFFSET = 8'h20;
  localparam logic [7:0] CTRL_THREE_OFFSET = 8'h24;
  localparam logic [7:0] CTRL_ONE_OFFSET = 8'h28;

  // Status one bit positions
  localparam int TXE_POS  = 7;
  localparam int TXD_POS  = 6;
  localparam int RXF_POS  = 5;
  localparam int IDLE_POS = 4;
  localparam int OVR_POS  = 3;
  localparam int NOI_POS  = 2;
  localparam int FRM_POS  = 1;
  localparam int PAR_POS  = 0;
  // Status two bit positions
  localparam int BRK_POS  = 1;
  localparam int ACT_POS  = 0;
  // Control three bit positions
  localparam int RX8_POS  = 7;
  localparam int TX8_POS  = 6;
  localparam int OIE_POS  = 3;
  localparam int NIE_POS  = 2;
  localparam int FIE_POS  = 1;
  localparam int PIE_POS  = 0;
  // Control one (own) bit positions
  localparam int NINE_POS = 0;
  localparam int RXEN_POS = 1;
  localparam int TEI_POS  = 2;
  localparam int TCI_POS  = 3;
  localparam int RFI_POS  = 4;
  localparam int ILI_POS  = 5;

  localparam logic [7:0] CTRL_ONE_RESET  = 8'h00;
  localparam logic [3:0] ERR_EN_RESET    = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0] HSIZE_WORD      = 3'h2;

  // Events from the receive shift logic
  typedef struct packed {
    logic       done;
    logic [8:0] data;
    logic       noise;
    logic       framing;
    logic       parity;
    logic       brk;
  } rx_event_s;

  // Events from the transmit shift logic
  typedef struct packed {
    logic load;
    logic busy;
    logic queued;
  } tx_event_s;

endpackage

// ### testbench/serial_status_regs_properties.sv
// Checker on the bus and transmit-buffer ports of the serial status block
// Assumes it is bound to serial_status_regs and clocked by CORE_CLK
`timescale 1ns/1ns
module serial_status_regs_checker
  import serial_status_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        CLK_EN,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire tx_event_s   TX_EVENT,
  input wire logic [8:0]  TX_DATA,
  input wire logic        TX_DATA_VALID,
  input wire logic        NINE_BIT_MODE,
  input wire logic        TX_IRQ,
  input wire logic        RX_IRQ,
  input wire logic        ERR_IRQ
);
  logic taken;
  logic unmapped;
  assign taken    = CLK_EN && HSEL && HREADY && HTRANS[1];
  assign unmapped = !(HADDR[7:0] inside {DATA_OFFSET, STAT_ONE_OFFSET, STAT_TWO_OFFSET, CTRL_THREE_OFFSET,
                      CTRL_ONE_OFFSET});
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  a_ready_always: assert property (HREADYOUT) else $error("ready low");
  a_resp_okay: assert property (!HRESP) else $error("response not okay");
  a_unmapped_zero: assert property (taken && !HWRITE && unmapped |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_write_pending: assert property (taken && HWRITE && HADDR[7:0] == DATA_OFFSET |-> ##[1:3] TX_DATA_VALID)
    else $error("data write not pending");
  a_load_empties: assert property (CLK_EN && TX_EVENT.load |=> !TX_DATA_VALID)
    else $error("pending after load");
  a_pending_holds: assert property (TX_DATA_VALID && !TX_EVENT.load |=> TX_DATA_VALID)
    else $error("pending lost");
  a_freeze_state: assert property (!CLK_EN |=> $stable({TX_IRQ, RX_IRQ, ERR_IRQ, TX_DATA_VALID}))
    else $error("state moved while frozen");
  a_eight_bit_tx: assert property (!NINE_BIT_MODE && TX_DATA_VALID |-> !TX_DATA[8])
    else $error("ninth bit in eight-bit mode");
endmodule // serial_status_regs_checker

bind serial_status_regs serial_status_regs_checker chk_i (.CORE_CLK, .SYS_RST, .CLK_EN, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .TX_EVENT, .TX_DATA, .TX_DATA_VALID, .NINE_BIT_MODE, .TX_IRQ,
  .RX_IRQ, .ERR_IRQ);

// ### testbench/serial_line_peer.sv
// Model of the shifters and line sampler beside the serial status block
// Assumes the bench calls rx and line after a clock edge
`timescale 1ns/1ns
module serial_line_peer
  import serial_status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_valid,
  input  wire logic [8:0] tx_data,
  output rx_event_s       rx_ev,
  output logic [3:0]      line_ev,
  output tx_event_s       tx_ev
);
  logic       stall = 1'b0;
  logic [8:0] last_tx;
  logic [3:0] busy_cnt;
  initial begin
    rx_ev   = '0;
    line_ev = '0;
    tx_ev   = '0;
  end
  // Shifter takes the buffer when free, then sends for eight cycles
  always @(posedge clk) begin
    if (rst) begin
      tx_ev    <= '0;
      busy_cnt <= 4'h0;
    end else begin
      tx_ev.busy <= busy_cnt != 4'h0;
      if (tx_valid && !tx_ev.load && busy_cnt == 4'h0 && !stall) begin
        tx_ev.load   <= 1'b1;
        tx_ev.queued <= 1'b1;
        last_tx      <= tx_data;
        busy_cnt     <= 4'h8;
      end else begin
        tx_ev.load   <= 1'b0;
        tx_ev.queued <= 1'b0;
        if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
      end
    end
  end
  // Completed character; flags are {noise, framing, parity, break}
  task automatic rx(input logic [8:0] d, input logic [3:0] f);
    @(posedge clk);
    rx_ev <= {1'b1, d, f};
    @(posedge clk);
    rx_ev <= {1'b0, ~d, 4'h0};
  endtask
  // Line pulse: {idle run, ones, start slot zero, false start}
  task automatic line(input logic [3:0] m);
    @(posedge clk);
    line_ev <= m;
    @(posedge clk);
    line_ev <= 4'h0;
  endtask
endmodule // serial_line_peer

// ### testbench/serial_status_regs_bench.sv
// Self-checking bench for the serial status block
// Assumes the checker is bound in and the line peer sits on the shifter side
`timescale 1ns/1ns
module serial_status_regs_bench
  import serial_status_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        clk_en;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata, r;
  logic        hready, hresp, tx_valid, nine, rxen, tx_irq, rx_irq, err_irq;
  logic [8:0]  tx_data;
  rx_event_s   rx_ev;
  tx_event_s   tx_ev;
  logic [3:0]  line_ev;
  int          mismatches = 0;
  int          total_checks = 0;

  always #10 clk = ~clk;

  serial_status_regs uut (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(clk_en), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .RX_EVENT(rx_ev), .LINE_IDLE_RUN(line_ev[3]), .LINE_ONES(line_ev[2]),
    .START_SLOT_ZERO(line_ev[1]), .FALSE_START(line_ev[0]), .TX_EVENT(tx_ev), .TX_DATA(tx_data),
    .TX_DATA_VALID(tx_valid), .NINE_BIT_MODE(nine), .RX_ENABLE(rxen), .TX_IRQ(tx_irq), .RX_IRQ(rx_irq),
    .ERR_IRQ(err_irq));
  serial_line_peer peer (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data), .rx_ev(rx_ev),
    .line_ev(line_ev), .tx_ev(tx_ev));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(r & m, e);
  endtask
  task automatic ic(input logic [2:0] e);
    repeat (4) @(posedge clk);
    chk({29'h0, tx_irq, rx_irq, err_irq}, {29'h0, e});
  endtask
  task automatic clr;
    rd(STAT_ONE_OFFSET);
    rd(DATA_OFFSET);
  endtask

  task automatic t_reset;
    rc(STAT_ONE_OFFSET, '1, 32'hc0);
    rc(STAT_TWO_OFFSET, '1, 32'h0);
    rc(CTRL_THREE_OFFSET, 32'hf, 32'h0);
    rc(CTRL_ONE_OFFSET, '1, 32'h0);
    wr(STAT_ONE_OFFSET, 32'h0);
    wr(8'h40, 32'hff);
    rc(STAT_ONE_OFFSET, '1, 32'hc0);
    rc(8'h40, '1, 32'h0);
  endtask
  task automatic t_rx;
    wr(CTRL_ONE_OFFSET, 32'h12);
    peer.rx(9'h0c3, 4'h0);
    ic(3'b010);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    rc(STAT_ONE_OFFSET, '1, 32'he0);
    rc(CTRL_THREE_OFFSET, 32'h80, 32'h80);
    rc(DATA_OFFSET, 32'hff, 32'hc3);
    rc(STAT_ONE_OFFSET, '1, 32'hc0);
    wr(CTRL_ONE_OFFSET, 32'h13);
    wr(CTRL_THREE_OFFSET, 32'h08);
    peer.rx(9'h1a5, 4'h0);
    peer.rx(9'h05a, 4'h0);
    ic(3'b011);
    rc(STAT_ONE_OFFSET, '1, 32'he8);
    rc(DATA_OFFSET, 32'hff, 32'ha5);
    rc(CTRL_THREE_OFFSET, 32'h80, 32'h80);
    rc(STAT_ONE_OFFSET, '1, 32'hc0);
    peer.rx(9'h011, 4'h0);
    rc(STAT_ONE_OFFSET, '1, 32'he0);
    peer.rx(9'h022, 4'h0);
    rc(DATA_OFFSET, 32'hff, 32'h11);
    rc(STAT_ONE_OFFSET, '1, 32'hc8);
    clr;
  endtask
  task automatic t_err;
    wr(CTRL_ONE_OFFSET, 32'h02);
    for (int p = 0; p < 3; p++) begin
      wr(CTRL_THREE_OFFSET, 32'h1 << ((p + 1) % 3));
      peer.rx(9'h055, 4'h1 << (p + 1));
      ic(3'b000);
      wr(CTRL_THREE_OFFSET, 32'h1 << p);
      ic(3'b001);
      rc(STAT_ONE_OFFSET, '1, 32'he0 | (32'h1 << p));
      rd(DATA_OFFSET);
      ic(3'b000);
    end
  endtask
  task automatic t_brk;
    wr(CTRL_ONE_OFFSET, 32'h03);
    peer.rx(9'h100, 4'h1);
    rc(STAT_ONE_OFFSET, '1, 32'he2);
    rc(CTRL_THREE_OFFSET, 32'h80, 32'h0);
    ic(3'b000);
    rc(STAT_TWO_OFFSET, '1, 32'h2);
    rd(DATA_OFFSET);
    rc(STAT_TWO_OFFSET, '1, 32'h0);
    peer.rx(9'h000, 4'h1);
    rc(STAT_TWO_OFFSET, '1, 32'h0);
    clr;
    peer.line(4'h4);
    peer.rx(9'h000, 4'h1);
    rc(STAT_TWO_OFFSET, '1, 32'h2);
    rd(DATA_OFFSET);
    clr;
  endtask
  task automatic t_idle;
    wr(CTRL_ONE_OFFSET, 32'h0);
    wr(CTRL_ONE_OFFSET, 32'h22);
    peer.line(4'h8);
    ic(3'b000);
    chk({31'h0, rxen}, 32'h1);
    peer.rx(9'h031, 4'h0);
    clr;
    peer.line(4'h8);
    ic(3'b010);
    rc(STAT_ONE_OFFSET, '1, 32'hd0);
    rd(DATA_OFFSET);
    peer.line(4'h8);
    rc(STAT_ONE_OFFSET, '1, 32'hc0);
    peer.line(4'h2);
    rc(STAT_TWO_OFFSET, '1, 32'h1);
    peer.line(4'h1);
    rc(STAT_TWO_OFFSET, '1, 32'h0);
    peer.line(4'h2);
    peer.line(4'h8);
    rc(STAT_TWO_OFFSET, '1, 32'h0);
  endtask
  task automatic t_tx;
    wr(CTRL_ONE_OFFSET, 32'h05);
    wr(CTRL_THREE_OFFSET, 32'h40);
    peer.stall <= 1'b1;
    ic(3'b100);
    chk({31'h0, nine}, 32'h1);
    rc(STAT_ONE_OFFSET, '1, 32'hc0);
    wr(DATA_OFFSET, 32'h3c);
    ic(3'b000);
    rc(STAT_ONE_OFFSET, '1, 32'h00);
    peer.stall <= 1'b0;
    ic(3'b100);
    chk({23'h0, peer.last_tx}, 32'h13c);
    rc(STAT_ONE_OFFSET, '1, 32'h80);
    repeat (12) @(posedge clk);
    rc(STAT_ONE_OFFSET, '1, 32'hc0);
    wr(CTRL_ONE_OFFSET, 32'h04);
    wr(DATA_OFFSET, 32'h5a);
    repeat (4) @(posedge clk);
    chk({23'h0, peer.last_tx}, 32'h05a);
    chk({31'h0, nine}, 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    rst    <= 1'b1;
    clk_en <= 1'b1;
    hsel   <= 1'b0;
    hwrite <= 1'b0;
    htrans <= 2'h0;
    hsize  <= 3'h0;
    haddr  <= 32'h0;
    hwdata <= 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rx;
    t_err;
    t_brk;
    t_idle;
    t_tx;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule // serial_status_regs_bench
